/* flash_seq_consts.vh */
// Constants for the flash erase/program sequencer: device map, own registers, timing
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// Device register selects on the device access port
`define DEV_SEL_CTRL      3'h0
`define DEV_SEL_KEY       3'h1
`define DEV_SEL_PAGE      3'h2
`define DEV_SEL_TWL       3'h3
`define DEV_SEL_TWH       3'h4

// Device flash control register fields
`define CTRL_START_BIT    15
`define CTRL_ARM_BIT      14
`define CTRL_ERASE_BIT    6
`define OPSEL_ERASE       4'h2
`define OPSEL_ROW         4'h1
`define CTRL_RESET        16'h0000

// Unlock keys
`define KEY_FIRST         16'h0055
`define KEY_SECOND        16'h00AA

// Row geometry: latch entries per row, table address step per entry
`define ROW_ENTRIES       64
`define LAT_IDX_LAST      6'h3F
`define TADDR_STEP        16'h0002

// Idle cycles after the start write before the first poll
`define NOP_CYCLES        2'h2

// Own register byte offsets (AXI4-Lite, one word each)
`define REG_CMD           8'h00
`define REG_STATUS        8'h04
`define REG_PAGE          8'h08
`define REG_OFFSET        8'h0C
`define REG_LATIDX        8'h10
`define REG_LATDAT        8'h14
`define REG_LAST_IDX      6'h05

// Own register fields
`define CMD_GO_BIT        0
`define CMD_OP_BIT        1
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* axil_reg_slave.v */
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"

module axil_reg_slave (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        ce,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready,
   output wire        reg_we,
   output wire [7:0]  reg_waddr,
   output wire [31:0] reg_wdata,
   output wire [3:0]  reg_wstrb,
   output wire [7:0]  reg_raddr,
   input  wire [31:0] reg_rdata
);

   reg        aw_full_r;
   reg        w_full_r;
   reg [7:0]  awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0]  wstrb_r;
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   reg        rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0]  rresp_r;

   function addr_hit;
      input [7:0] a;
      begin
         addr_hit = (a[1:0] == 2'h0) && (a[7:2] <= `REG_LAST_IDX);
      end
   endfunction

   assign awready   = ce & ~aw_full_r;
   assign wready    = ce & ~w_full_r;
   assign arready   = ce & ~rvalid_r;
   assign reg_we    = ce & aw_full_r & w_full_r & ~bvalid_r & addr_hit(awaddr_r);
   assign reg_waddr = awaddr_r;
   assign reg_wdata = wdata_r;
   assign reg_wstrb = wstrb_r;
   assign reg_raddr = araddr;
   assign bvalid    = bvalid_r;
   assign bresp     = bresp_r;
   assign rvalid    = rvalid_r;
   assign rdata     = rdata_r;
   assign rresp     = rresp_r;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= awaddr;
         end
         if (wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
         end
         // Response once both halves are held
         if (aw_full_r && w_full_r && !bvalid_r) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= addr_hit(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
         if (arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= addr_hit(araddr) ? reg_rdata : 32'h00000000;
            rresp_r  <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

/* flash_seq_host.v */
// Host-side sequencer driving the flash erase and row program steps
//
// Operation
// [RULE1] Device programs one row; erase clears the eight-row block around it.
// [RULE2] Software copies the eight block rows to RAM and merges new data.
// [RULE3] Operation select value 0010 in bits 3..0 selects block erase.
// [RULE4] Block erase needs erase flag bit 6 and write-arm bit 14 set.
// [RULE5] Erase target is page pointer plus in-page address from a table write.
// [RULE6] Keys 55h then AAh must directly precede setting the start bit.
// [RULE7] Start bit 15 begins the cycle; device stalls its CPU throughout.
// [RULE8] Device clears start bit at completion; completion is found by polling.
// [RULE9] Value 0001 selects row program, erase flag clear, write-arm set.
// [RULE10] Sixty-four write latches are filled before each row program.
// [RULE11] Low word write then high byte write; second advances latch pointer.
// [RULE12] Repeat latch load and program, advancing page pointer, over the block.
// [RULE13] Hold off lower-priority interrupts during key writes and start.
// [RULE14] Two idle slots follow the start; wait for completion before use.
// [RULE15] Device ignores start when not armed or unlock sequence was broken.
// [RULE16] Device ignores operation select and latch writes while busy.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"

module flash_seq_host (
   input  wire        MCLK,
   input  wire        ARST_N,
   input  wire        CE,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output wire [1:0]  S_AXI_BRESP,
   output wire        S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0]  S_AXI_RRESP,
   output wire        S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg  [2:0]  DEV_SEL,
   output reg  [15:0] DEV_WDATA,
   output reg  [15:0] DEV_TADDR,
   output reg         DEV_WE,
   output reg         DEV_RE,
   input  wire [15:0] DEV_RDATA,
   output reg         IRQ_HOLDOFF
);

   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_CTRL  = 4'h1;
   localparam [3:0] ST_PAGE  = 4'h2;
   localparam [3:0] ST_TADDR = 4'h3;
   localparam [3:0] ST_LATL  = 4'h4;
   localparam [3:0] ST_LATH  = 4'h5;
   localparam [3:0] ST_KEY1  = 4'h6;
   localparam [3:0] ST_KEY2  = 4'h7;
   localparam [3:0] ST_START = 4'h8;
   localparam [3:0] ST_NOP   = 4'h9;
   localparam [3:0] ST_POLL  = 4'hA;
   localparam [3:0] ST_CHECK = 4'hB;

   wire        reg_we;
   wire [7:0]  reg_waddr;
   wire [31:0] reg_wdata;
   wire [3:0]  reg_wstrb;
   wire [7:0]  reg_raddr;
   reg  [31:0] reg_rdata;

   reg [3:0]  state_r;
   reg        op_row_r;
   reg        done_r;
   reg [7:0]  page_r;
   reg [15:0] offset_r;
   reg [5:0]  latidx_r;
   reg [5:0]  lat_cnt_r;
   reg [15:0] taddr_r;
   reg [1:0]  nop_cnt_r;
   // Row image, kept across row programs until software rewrites it
   reg [23:0] lat_buf_r [0:`ROW_ENTRIES-1];
   integer    i;

   // Busy from the accepted go command, one cycle before the first device write, to the completion poll
   wire busy = (state_r != ST_IDLE);

   // Merge a bus write into a held value, honouring byte strobes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
         end
      end
   endfunction

   // Control word for the selected operation
   function [15:0] ctrl_word;
      input row;
      input start;
      begin
         ctrl_word = `CTRL_RESET;
         ctrl_word[`CTRL_ARM_BIT] = 1'b1;
         ctrl_word[`CTRL_START_BIT] = start;
         if (row) begin
            ctrl_word[3:0] = `OPSEL_ROW;
         end else begin
            ctrl_word[3:0] = `OPSEL_ERASE;
            ctrl_word[`CTRL_ERASE_BIT] = 1'b1;
         end
      end
   endfunction

   // Byte-strobe merges for the setup registers and the row image
   wire [31:0] page_mrg   = merge({24'h000000, page_r}, reg_wdata, reg_wstrb);
   wire [31:0] offset_mrg = merge({16'h0000, offset_r}, reg_wdata, reg_wstrb);
   wire [31:0] lat_mrg    = merge({8'h00, lat_buf_r[latidx_r]}, reg_wdata, reg_wstrb);

   // Bus front end; write strobes reach the register block for one cycle
   axil_reg_slave u_slave (
      .clk       (MCLK),
      .arst_n    (ARST_N),
      .ce        (CE),
      .awaddr    (S_AXI_AWADDR),
      .awvalid   (S_AXI_AWVALID),
      .awready   (S_AXI_AWREADY),
      .wdata     (S_AXI_WDATA),
      .wstrb     (S_AXI_WSTRB),
      .wvalid    (S_AXI_WVALID),
      .wready    (S_AXI_WREADY),
      .bresp     (S_AXI_BRESP),
      .bvalid    (S_AXI_BVALID),
      .bready    (S_AXI_BREADY),
      .araddr    (S_AXI_ARADDR),
      .arvalid   (S_AXI_ARVALID),
      .arready   (S_AXI_ARREADY),
      .rdata     (S_AXI_RDATA),
      .rresp     (S_AXI_RRESP),
      .rvalid    (S_AXI_RVALID),
      .rready    (S_AXI_RREADY),
      .reg_we    (reg_we),
      .reg_waddr (reg_waddr),
      .reg_wdata (reg_wdata),
      .reg_wstrb (reg_wstrb),
      .reg_raddr (reg_raddr),
      .reg_rdata (reg_rdata)
   );

   // Read mux for the own registers
   always @* begin
      reg_rdata = 32'h00000000;
      case (reg_raddr)
         `REG_CMD: begin
            reg_rdata[`CMD_OP_BIT] = op_row_r;
         end
         `REG_STATUS: begin
            reg_rdata[`STAT_BUSY_BIT] = busy;
            reg_rdata[`STAT_DONE_BIT] = done_r;
            reg_rdata[7:4] = state_r;
         end
         `REG_PAGE:   reg_rdata[7:0] = page_r;
         `REG_OFFSET: reg_rdata[15:0] = offset_r;
         `REG_LATIDX: reg_rdata[5:0] = latidx_r;
         `REG_LATDAT: reg_rdata[23:0] = lat_buf_r[latidx_r];
         default:     reg_rdata = 32'h00000000;
      endcase
   end

   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r     <= ST_IDLE;
         op_row_r    <= 1'b0;
         done_r      <= 1'b0;
         page_r      <= 8'h00;
         offset_r    <= 16'h0000;
         latidx_r    <= 6'h00;
         lat_cnt_r   <= 6'h00;
         taddr_r     <= 16'h0000;
         nop_cnt_r   <= 2'h0;
         DEV_SEL     <= `DEV_SEL_CTRL;
         DEV_WDATA   <= 16'h0000;
         DEV_TADDR   <= 16'h0000;
         DEV_WE      <= 1'b0;
         DEV_RE      <= 1'b0;
         IRQ_HOLDOFF <= 1'b0;
         for (i = 0; i < `ROW_ENTRIES; i = i + 1) begin
            lat_buf_r[i] <= 24'h000000;
         end
      end else if (CE) begin
         DEV_WE <= 1'b0;
         DEV_RE <= 1'b0;

         // Software side; setup registers are frozen while a sequence runs
         if (reg_we) begin
            case (reg_waddr)
               `REG_CMD: begin
                  if (!busy && reg_wstrb[0] && reg_wdata[`CMD_GO_BIT]) begin
                     op_row_r <= reg_wdata[`CMD_OP_BIT];
                     state_r  <= ST_CTRL;
                  end
               end
               `REG_STATUS: begin
                  // Write one clears done; a completion in the same cycle wins
                  if (reg_wstrb[0] && reg_wdata[`STAT_DONE_BIT]) begin
                     done_r <= 1'b0;
                  end
               end
               `REG_PAGE: begin
                  if (!busy) begin
                     page_r <= page_mrg[7:0];
                  end
               end
               `REG_OFFSET: begin
                  if (!busy) begin
                     offset_r <= offset_mrg[15:0]; // RULE16
                  end
               end
               `REG_LATIDX: begin
                  if (!busy && reg_wstrb[0]) begin
                     latidx_r <= reg_wdata[5:0];
                  end
               end
               `REG_LATDAT: begin
                  // RAM image of one row, filled before a row program
                  if (!busy) begin
                     lat_buf_r[latidx_r] <= lat_mrg[23:0]; // RULE10 RULE16
                     latidx_r <= latidx_r + 6'h01;
                  end
               end
               default: begin
               end
            endcase
         end

         // Device-side sequence, one device access per cycle
         case (state_r)
            ST_IDLE: begin
               IRQ_HOLDOFF <= 1'b0;
            end
            ST_CTRL: begin
               DEV_SEL   <= `DEV_SEL_CTRL;
               DEV_WDATA <= ctrl_word(op_row_r, 1'b0); // RULE3 RULE4 RULE9
               DEV_WE    <= 1'b1;
               state_r   <= ST_PAGE;
            end
            // Row program loads the latches; erase needs one table write
            ST_PAGE: begin
               DEV_SEL   <= `DEV_SEL_PAGE;
               DEV_WDATA <= {8'h00, page_r}; // RULE5
               DEV_WE    <= 1'b1;
               lat_cnt_r <= 6'h00;
               taddr_r   <= offset_r;
               state_r   <= op_row_r ? ST_LATL : ST_TADDR;
            end
            ST_TADDR: begin
               DEV_SEL   <= `DEV_SEL_TWL;
               DEV_TADDR <= offset_r; // RULE5
               DEV_WDATA <= offset_r;
               DEV_WE    <= 1'b1;
               state_r   <= ST_KEY1;
            end
            ST_LATL: begin
               DEV_SEL   <= `DEV_SEL_TWL;
               DEV_TADDR <= taddr_r;
               DEV_WDATA <= lat_buf_r[lat_cnt_r][15:0]; // RULE11
               DEV_WE    <= 1'b1;
               state_r   <= ST_LATH;
            end
            // High byte write of each entry advances the latch pointer
            ST_LATH: begin
               DEV_SEL   <= `DEV_SEL_TWH;
               DEV_TADDR <= taddr_r;
               DEV_WDATA <= {8'h00, lat_buf_r[lat_cnt_r][23:16]}; // RULE11
               DEV_WE    <= 1'b1;
               taddr_r   <= taddr_r + `TADDR_STEP;
               lat_cnt_r <= lat_cnt_r + 6'h01;
               state_r   <= (lat_cnt_r == `LAT_IDX_LAST) ? ST_KEY1 : ST_LATL; // RULE1 RULE10
            end
            // Interrupts held off from the first key through the first of the two idle slots
            ST_KEY1: begin
               IRQ_HOLDOFF <= 1'b1; // RULE13
               DEV_SEL     <= `DEV_SEL_KEY;
               DEV_WDATA   <= `KEY_FIRST; // RULE6
               DEV_WE      <= 1'b1;
               state_r     <= ST_KEY2;
            end
            ST_KEY2: begin
               DEV_SEL   <= `DEV_SEL_KEY;
               DEV_WDATA <= `KEY_SECOND; // RULE6
               DEV_WE    <= 1'b1;
               state_r   <= ST_START;
            end
            ST_START: begin
               // Start follows the second key with no other device write between
               DEV_SEL   <= `DEV_SEL_CTRL;
               DEV_WDATA <= ctrl_word(op_row_r, 1'b1); // RULE7 RULE15
               DEV_WE    <= 1'b1;
               nop_cnt_r <= `NOP_CYCLES;
               state_r   <= ST_NOP;
            end
            // Two idle slots after the start, no device access in them
            ST_NOP: begin
               nop_cnt_r <= nop_cnt_r - 2'h1;
               if (nop_cnt_r == 2'h1) begin
                  IRQ_HOLDOFF <= 1'b0;
                  state_r     <= ST_POLL; // RULE14
               end
            end
            // Read the control register until the device drops the start bit
            ST_POLL: begin
               DEV_SEL <= `DEV_SEL_CTRL;
               DEV_RE  <= 1'b1;
               state_r <= ST_CHECK;
            end
            ST_CHECK: begin
               // Data is valid the cycle after the read strobe
               if (!DEV_RE) begin
                  if (DEV_RDATA[`CTRL_START_BIT]) begin
                     state_r <= ST_POLL; // RULE8
                  end else begin
                     done_r  <= 1'b1; // RULE8
                     state_r <= ST_IDLE;
                     if (op_row_r) begin
                        page_r <= page_r + 8'h01; // RULE12
                     end
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* flash_seq_host_props.sv */
// Checker for the sequencer's device port and AXI answers
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module flash_seq_host_props (
   input wire logic        MCLK,
   input wire logic        ARST_N,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [2:0]  DEV_SEL,
   input wire logic [15:0] DEV_WDATA,
   input wire logic [15:0] DEV_TADDR,
   input wire logic        DEV_WE,
   input wire logic        DEV_RE,
   input wire logic        IRQ_HOLDOFF
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   wire        keyw = DEV_WE && DEV_SEL == `DEV_SEL_KEY;
   wire        k1   = keyw && DEV_WDATA == `KEY_FIRST;
   wire        k2   = keyw && DEV_WDATA == `KEY_SECOND;
   wire        ctlw = DEV_WE && DEV_SEL == `DEV_SEL_CTRL;
   wire        go   = ctlw && DEV_WDATA[15];
   wire        twl  = DEV_WE && DEV_SEL == `DEV_SEL_TWL;
   wire        twh  = DEV_WE && DEV_SEL == `DEV_SEL_TWH;
   logic       k2_r;
   logic [15:0] ta_r;
   // Remembers the second-key write of the last cycle and the address of the last low-word write
   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         k2_r <= 1'b0;
         ta_r <= 16'h0000;
      end else begin
         k2_r <= k2;
         if (twl) ta_r <= DEV_TADDR;
      end
   end
   a_key_pair: assert property (k1 |=> k2) else $error("second key missing");
   a_start_follows: assert property (k2 |=> go && DEV_WDATA[14])
      else $error("start not after keys");
   a_start_keyed: assert property (go |-> k2_r) else $error("start without keys");
   a_erase_fields: assert property (ctlw && DEV_WDATA[6] |->
      DEV_WDATA[3:0] == `OPSEL_ERASE && DEV_WDATA[14]) else $error("bad erase word");
   a_row_fields: assert property (ctlw && DEV_WDATA[3:0] == `OPSEL_ROW |->
      !DEV_WDATA[6] && DEV_WDATA[14]) else $error("bad row word");
   a_high_pairs: assert property (twh |-> DEV_TADDR == ta_r)
      else $error("high byte address differs");
   a_holdoff_keys: assert property (keyw |-> IRQ_HOLDOFF) else $error("keys unguarded");
   a_idle_after_go: assert property (go |=> (!DEV_WE && !DEV_RE) [*2])
      else $error("no idle after start");
   a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   c_erase: cover property (go && DEV_WDATA[3:0] == `OPSEL_ERASE);
   c_row: cover property (go && DEV_WDATA[3:0] == `OPSEL_ROW);
   c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == `RESP_SLVERR);
endmodule
bind flash_seq_host flash_seq_host_props chk (.MCLK(MCLK), .ARST_N(ARST_N),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .DEV_SEL(DEV_SEL), .DEV_WDATA(DEV_WDATA), .DEV_TADDR(DEV_TADDR), .DEV_WE(DEV_WE),
   .DEV_RE(DEV_RE), .IRQ_HOLDOFF(IRQ_HOLDOFF));
`default_nettype wire

/* flash_dev_model.sv */
// Behavioural flash device answering the sequencer's register port
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module flash_dev_model #(
   parameter int BUSY_CYC = 40
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [2:0]  sel,
   input  wire logic [15:0] wdat,
   input  wire logic [15:0] taddr,
   input  wire logic        we,
   input  wire logic        re,
   output logic      [15:0] rdat
);
   logic [15:0] ctrl_r, page_r, erase_taddr_r, row_page_r;
   logic [23:0] lat [0:63];
   logic [1:0]  key_r;
   int          busy_cnt, n_erase, n_row, n_bad;
   wire         idle = (busy_cnt == 0);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `CTRL_RESET;
         page_r <= 16'h0000;
         key_r <= 2'h0;
         busy_cnt <= 0;
         n_erase <= 0;
         n_row <= 0;
         n_bad <= 0;
         rdat <= 16'h0000;
      end else begin
         // Unread cycles invert the previous output each cycle, so the last read value returns every other cycle
         rdat <= re ? ctrl_r : ~rdat;
         if (!idle) busy_cnt <= busy_cnt - 1;
         if (busy_cnt == 1) ctrl_r[15] <= 1'b0;
         if (we) begin
            key_r <= (sel == `DEV_SEL_KEY && wdat == `KEY_FIRST) ? 2'h1 :
               (sel == `DEV_SEL_KEY && wdat == `KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
            case (sel)
               `DEV_SEL_CTRL: begin
                  if (!wdat[15]) begin
                     if (idle) ctrl_r <= wdat;
                  end else if (idle && key_r == 2'h2 && wdat[14]) begin
                     ctrl_r <= wdat;
                     busy_cnt <= BUSY_CYC;
                     if (wdat[3:0] == `OPSEL_ERASE && wdat[6]) n_erase <= n_erase + 1;
                     if (wdat[3:0] == `OPSEL_ROW && !wdat[6]) begin
                        n_row <= n_row + 1;
                        row_page_r <= page_r;
                     end
                  end else n_bad <= n_bad + 1;
               end
               `DEV_SEL_PAGE: page_r <= wdat;
               `DEV_SEL_TWL: if (idle) begin
                  lat[taddr[6:1]][15:0] <= wdat;
                  erase_taddr_r <= taddr;
               end
               `DEV_SEL_TWH: if (idle) lat[taddr[6:1]][23:16] <= wdat[7:0];
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* test_flash_seq_host.sv */
// Testbench for the flash sequencer host against a device model
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module test_flash_seq_host;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [7:0]  araddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, dev_we, dev_re, holdoff;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [2:0]  dev_sel;
   wire  [15:0] dev_wdata, dev_taddr, dev_rdata;
   int          err_count = 0;
   int          n_compared = 0;
   logic [31:0] d;
   logic [1:0]  r;

   always #25 mclk = ~mclk;

   flash_seq_host uut (.MCLK(mclk), .ARST_N(arst_n), .CE(1'b1),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .DEV_SEL(dev_sel), .DEV_WDATA(dev_wdata), .DEV_TADDR(dev_taddr), .DEV_WE(dev_we),
      .DEV_RE(dev_re), .DEV_RDATA(dev_rdata), .IRQ_HOLDOFF(holdoff));
   flash_dev_model #(.BUSY_CYC(40)) dev (.clk(mclk), .arst_n(arst_n), .sel(dev_sel),
      .wdat(dev_wdata), .taddr(dev_taddr), .we(dev_we), .re(dev_re), .rdat(dev_rdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Readies and answers are sampled mid-cycle, where they are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic sa, sw, sb;
      @(posedge mclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      sb = 1'b0;
      while (!sb) begin
         @(negedge mclk);
         sa = awvalid && awready;
         sw = wvalid && wready;
         sb = bvalid;
         r = bresp;
         @(posedge mclk);
         if (sa) awvalid <= 1'b0;
         if (sw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic sa, sr;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      sr = 1'b0;
      while (!sr) begin
         @(negedge mclk);
         sa = arvalid && arready;
         sr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (sa) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   function automatic logic [23:0] pat(input int i);
      return {8'(i) ^ 8'h5A, 16'hC300 + 16'(i)};
   endfunction

   task automatic wait_done;
      d = 32'h0000_0000;
      for (int i = 0; i < 400 && d[1] !== 1'b1; i++) rd(`REG_STATUS);
      chk(d & 32'h0000_0003, 32'h0000_0002);
   endtask

   task automatic t_reset;
      rd(`REG_STATUS);
      chk(d & 32'h0000_0003, 32'h0000_0000);
      rd(`REG_PAGE);
      chk(d, 32'h0000_0000);
      rd(8'h18);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      wr(8'h1C, 32'hFFFF_FFFF);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
   endtask

   task automatic t_erase;
      wr(`REG_PAGE, 32'h0000_0012);
      wr(`REG_OFFSET, 32'h0000_0400);
      wr(`REG_CMD, 32'h0000_0001);
      rd(`REG_STATUS);
      chk(d & 32'h0000_0001, 32'h0000_0001);
      wait_done;
      chk(dev.n_erase, 32'h0000_0001);
      chk({16'h0, dev.erase_taddr_r}, 32'h0000_0400);
      chk({16'h0, dev.page_r}, 32'h0000_0012);
      chk(dev.n_bad, 32'h0000_0000);
      chk({31'h0, dev.ctrl_r[15]}, 32'h0000_0000);
   endtask

   task automatic t_row;
      wr(`REG_STATUS, 32'h0000_0002);
      wr(`REG_LATIDX, 32'h0000_0000);
      for (int i = 0; i < 64; i++) wr(`REG_LATDAT, {8'h00, pat(i)});
      wr(`REG_OFFSET, 32'h0000_6000);
      wr(`REG_CMD, 32'h0000_0003);
      wr(`REG_OFFSET, 32'h0000_1234);
      wait_done;
      for (int i = 0; i < 64; i++) chk({8'h00, dev.lat[i]}, {8'h00, pat(i)});
      chk(dev.n_row, 32'h0000_0001);
      chk({16'h0, dev.row_page_r}, 32'h0000_0012);
      rd(`REG_PAGE);
      chk(d, 32'h0000_0013);
      rd(`REG_OFFSET);
      chk(d, 32'h0000_6000);
      wr(`REG_LATIDX, 32'h0000_0005);
      rd(`REG_LATDAT);
      chk(d, {8'h00, pat(5)});
   endtask

   task automatic t_clear;
      wr(`REG_STATUS, 32'h0000_0002);
      rd(`REG_STATUS);
      chk(d & 32'h0000_0003, 32'h0000_0000);
   endtask

   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #400000;
      err_count++;
      report_and_stop;
   end

   initial begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset;
      t_erase;
      t_row;
      t_clear;
      report_and_stop;
   end
endmodule
`default_nettype wire
